// ===== pbsr_map.vh
// Purpose: constants for the pipelined burst memory read port
// Assumes: included by bare name
// Notes: definitions only
`ifndef PBSR_MAP_VH
`define PBSR_MAP_VH
`define PBSR_AW 10
`define PBSR_DW 36
`define PBSR_BL 4
`define PBSR_DEPTH 1024
`define PBSR_FIFO_DEPTH 4
`define PBSR_FIFO_PW 2
`define PBSR_SLEEP_NS 20
`define PBSR_CLK_NS 10
`define PBSR_SLEEP_CYC ((`PBSR_SLEEP_NS + `PBSR_CLK_NS - 1) / `PBSR_CLK_NS)
`define PBSR_LIN 1'b0
`define PBSR_ONE2 2'h1
`define PBSR_ZERO_D 36'h000000000
`endif

// ===== pbsr_fifo.v
// Purpose: small FIFO in the read data path
// Assumes: one clock, asynchronous active-high reset
// Notes: flip-flop storage addressed by index
`timescale 1ns/10ps
`default_nettype none
module pbsr_fifo #(
  parameter W = 36,
  parameter D = 4,
  parameter PW = 2
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_valid,
  output wire o_ready,
  input wire [W-1:0] i_data,
  output wire o_valid,
  input wire i_ready,
  output wire [W-1:0] o_data
);
  reg [W-1:0] mem_q [0:D-1];
  reg [PW-1:0] wp_q;
  reg [PW-1:0] rp_q;
  reg [PW:0] cnt_q;
  wire push;
  wire pop;
  assign o_ready = (cnt_q != D[PW:0]);
  assign o_valid = (cnt_q != {(PW+1){1'b0}});
  assign o_data = mem_q[rp_q];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;
  always @(posedge i_clk) begin
    if (push) begin
      mem_q[wp_q] <= i_data;
    end
  end
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wp_q <= {PW{1'b0}};
      rp_q <= {PW{1'b0}};
      cnt_q <= {(PW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + {{(PW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rp_q <= rp_q + {{(PW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + {{PW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - {{PW{1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// ===== pbsr_top.v
// Purpose: device-side logic of a pipelined burst memory, read path
// Assumes: all pins synchronous to I_MCLK except I_SLEEP_REQUEST and the asynchronous I_RESET
// Notes: read words pass a 4-word FIFO before the output register
`timescale 1ns/10ps
`default_nettype none
`include "pbsr_map.vh"
module pbsr_top (
  input wire I_MCLK,
  input wire I_RESET,
  input wire I_CLOCK_QUALIFIER_N,
  input wire I_CHIP_SEL_1_N,
  input wire I_CHIP_SEL_2,
  input wire I_CHIP_SEL_3_N,
  input wire I_ADVANCE_OR_LOAD,
  input wire I_WRITE_SEL_N,
  input wire [3:0] I_BYTE_LANE_WRITE_N,
  input wire I_BURST_ORDER,
  input wire I_OUT_DRIVE_EN_N,
  input wire I_SLEEP_REQUEST,
  input wire [`PBSR_AW-1:0] I_ADDR,
  input wire [`PBSR_DW-1:0] I_DATA_IN,
  output reg [`PBSR_DW-1:0] O_DATA_OUT,
  output reg O_DATA_OE,
  output reg O_SLEEPING
);
  //////////////////////////////////////////////////////////////////////////
  // Input registers
  reg cq_n_q, cs1_n_q, cs2_q, cs3_n_q, adv_q, wsel_n_q, bord_q, oe_n_q;
  reg [3:0] bw_n_q;
  reg [`PBSR_AW-1:0] addr_in_q;
  reg [`PBSR_DW-1:0] din_q;
  reg zz_m_q, zz_q;
  always @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      cq_n_q <= 1'b1;
      cs1_n_q <= 1'b1;
      cs2_q <= 1'b0;
      cs3_n_q <= 1'b1;
      adv_q <= 1'b0;
      wsel_n_q <= 1'b1;
      bord_q <= 1'b0;
      oe_n_q <= 1'b1;
      bw_n_q <= 4'hF;
      addr_in_q <= {`PBSR_AW{1'b0}};
      din_q <= `PBSR_ZERO_D;
      zz_m_q <= 1'b0;
      zz_q <= 1'b0;
    end else begin
      cq_n_q <= I_CLOCK_QUALIFIER_N;
      cs1_n_q <= I_CHIP_SEL_1_N;
      cs2_q <= I_CHIP_SEL_2;
      cs3_n_q <= I_CHIP_SEL_3_N;
      adv_q <= I_ADVANCE_OR_LOAD;
      wsel_n_q <= I_WRITE_SEL_N;
      bord_q <= I_BURST_ORDER;
      oe_n_q <= I_OUT_DRIVE_EN_N;
      bw_n_q <= I_BYTE_LANE_WRITE_N;
      addr_in_q <= I_ADDR;
      din_q <= I_DATA_IN;
      // Asynchronous pin: two-stage synchroniser
      zz_m_q <= I_SLEEP_REQUEST;
      zz_q <= zz_m_q;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Burst sequencing
  function [1:0] beat_addr;
    input [1:0] start;
    input [1:0] beat;
    input order;
    begin
      if (order == `PBSR_LIN) begin
        beat_addr = start + beat;
      end else begin
        beat_addr = start ^ beat;
      end
    end
  endfunction
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_SLEEP = 2'h2;
  localparam ST_WAKE = 2'h3;
  reg [1:0] st_q;
  reg [1:0] zcnt_q;
  reg [`PBSR_AW-1:0] base_q;
  reg [1:0] beat_q;
  reg dir_wr_q, sel_q, order_q;
  reg [`PBSR_DW-1:0] mem_q [0:`PBSR_DEPTH-1];
  wire run = (st_q == ST_RUN) & ~cq_n_q;
  wire sel = ~cs1_n_q & cs2_q & ~cs3_n_q;
  wire load = run & ~adv_q;
  wire [1:0] nbeat = beat_q + `PBSR_ONE2;
  wire [1:0] low_now = load ? addr_in_q[1:0] :
    beat_addr(base_q[1:0], nbeat, order_q);
  wire [`PBSR_AW-1:0] acc_addr = load ? addr_in_q :
    {base_q[`PBSR_AW-1:2], low_now};
  wire acc_sel = load ? sel : sel_q;
  wire acc_wr = load ? ~wsel_n_q : dir_wr_q;
  wire access = run & acc_sel;
  always @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      st_q <= ST_IDLE;
      zcnt_q <= 2'h0;
      base_q <= {`PBSR_AW{1'b0}};
      beat_q <= 2'h0;
      dir_wr_q <= 1'b0;
      sel_q <= 1'b0;
      order_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          st_q <= ST_RUN;
        end
        ST_RUN: begin
          if (zz_q) begin
            st_q <= ST_SLEEP;
            zcnt_q <= 2'h0;
          end else if (load) begin
            base_q <= addr_in_q;
            beat_q <= 2'h0;
            dir_wr_q <= ~wsel_n_q;
            sel_q <= sel;
            order_q <= bord_q;
          end else if (run) begin
            beat_q <= nbeat;
          end
        end
        ST_SLEEP: begin
          if (zcnt_q != `PBSR_SLEEP_CYC) begin
            zcnt_q <= zcnt_q + `PBSR_ONE2;
          end else if (~zz_q) begin
            st_q <= ST_WAKE;
            zcnt_q <= 2'h0;
          end
        end
        ST_WAKE: begin
          if (zcnt_q != `PBSR_SLEEP_CYC - 1) begin
            zcnt_q <= zcnt_q + `PBSR_ONE2;
          end else begin
            st_q <= ST_RUN;
            sel_q <= 1'b0;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Memory array; write data taken in the same cycle for simplicity
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : lane
      localparam LO = g * 9;
      always @(posedge I_MCLK) begin
        if (access & acc_wr & ~bw_n_q[g]) begin
          mem_q[acc_addr][LO+8:LO] <= din_q[LO+8:LO];
        end
      end
    end
  endgenerate
  //////////////////////////////////////////////////////////////////////////
  // Read path through FIFO, then output register
  wire rd_push = access & ~acc_wr;
  wire f_rdy, f_vld;
  wire [`PBSR_DW-1:0] f_data;
  pbsr_fifo #(
    .W(`PBSR_DW),
    .D(`PBSR_FIFO_DEPTH),
    .PW(`PBSR_FIFO_PW)
  ) u_fifo (
    .i_clk(I_MCLK),
    .i_rst(I_RESET),
    .i_valid(rd_push),
    .o_ready(f_rdy),
    .i_data(mem_q[acc_addr]),
    .o_valid(f_vld),
    .i_ready(~cq_n_q),
    .o_data(f_data)
  );
  // Drained on every qualified edge, so occupancy is at most one word
  // Drive enable is delayed one stage so it lines up with the data word
  reg oe_p_q;
  always @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_DATA_OUT <= `PBSR_ZERO_D;
      O_DATA_OE <= 1'b0;
      O_SLEEPING <= 1'b0;
      oe_p_q <= 1'b0;
    end else begin
      O_SLEEPING <= (st_q == ST_SLEEP);
      if (f_vld & ~cq_n_q) begin
        O_DATA_OUT <= f_data;
      end
      if (st_q != ST_RUN) begin
        oe_p_q <= 1'b0;
        O_DATA_OE <= 1'b0;
      end else if (~cq_n_q) begin
        oe_p_q <= rd_push & f_rdy;
        O_DATA_OE <= oe_p_q & ~oe_n_q;
      end
    end
  end
endmodule
`default_nettype wire

// ===== pbsr_props.sv
// Purpose: port checks for pbsr_top
// Assumes: hand-over latencies
// Notes: calm means running, driving, awake
`timescale 1ns/10ps
`default_nettype none
module pbsr_props (
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic I_CLOCK_QUALIFIER_N,
  input wire logic I_CHIP_SEL_1_N,
  input wire logic I_CHIP_SEL_2,
  input wire logic I_CHIP_SEL_3_N,
  input wire logic I_ADVANCE_OR_LOAD,
  input wire logic I_WRITE_SEL_N,
  input wire logic I_OUT_DRIVE_EN_N,
  input wire logic I_SLEEP_REQUEST,
  input wire logic O_DATA_OE,
  input wire logic O_SLEEPING
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  logic rdy_q;
  wire logic calm;
  wire logic sel;
  // Edge 0 after reset is idle by design
  always_ff @(posedge I_MCLK or posedge I_RESET)
    if (I_RESET) rdy_q <= 1'h0;
    else rdy_q <= 1'h1;
  assign calm = rdy_q && !I_CLOCK_QUALIFIER_N && !I_OUT_DRIVE_EN_N
    && !I_SLEEP_REQUEST && !O_SLEEPING;
  assign sel = !I_CHIP_SEL_1_N && I_CHIP_SEL_2 && !I_CHIP_SEL_3_N;
  sequence s_ld(w);
    calm && !I_ADVANCE_OR_LOAD && sel && I_WRITE_SEL_N == w;
  endsequence
  sequence s_adv;
    calm && I_ADVANCE_OR_LOAD;
  endsequence
  property p_rd; s_ld(1'h1) ##1 calm [*2] |=> O_DATA_OE; endproperty
  a_rd: assert property (p_rd) else $error("read late");
  property p_ds;
    calm && !I_ADVANCE_OR_LOAD && !sel ##1 calm [*2] |=> !O_DATA_OE;
  endproperty
  a_ds: assert property (p_ds) else $error("deselect drives");
  property p_rb; s_ld(1'h1) ##1 s_adv [*3] |-> O_DATA_OE [*4]; endproperty
  a_rb: assert property (p_rb) else $error("burst short");
  property p_wb; s_ld(1'h0) ##1 s_adv [*3] |-> !O_DATA_OE [*4];
  endproperty
  a_wb: assert property (p_wb) else $error("write drives");
  property p_oe;
    (I_OUT_DRIVE_EN_N && !I_CLOCK_QUALIFIER_N) [*5] |-> !O_DATA_OE;
  endproperty
  a_oe: assert property (p_oe) else $error("drive while off");
  property p_fz; I_CLOCK_QUALIFIER_N [*3] |=> $stable(O_DATA_OE); endproperty
  a_fz: assert property (p_fz) else $error("moved while frozen");
  property p_zi; (I_SLEEP_REQUEST && rdy_q) [*8] |-> O_SLEEPING; endproperty
  a_zi: assert property (p_zi) else $error("no sleep");
  property p_zo; (!I_SLEEP_REQUEST && rdy_q) [*8] |-> !O_SLEEPING; endproperty
  a_zo: assert property (p_zo) else $error("no wake");
endmodule
bind pbsr_top pbsr_props chk (.*);
`default_nettype wire

// ===== pbsr_ctl.sv
// Purpose: memory controller model on the pins
// Assumes: pins change on the falling edge
// Notes: one op call is one clock cycle
`timescale 1ns/10ps
`default_nettype none
module pbsr_ctl (
  input wire logic I_MCLK,
  output var logic I_CLOCK_QUALIFIER_N,
  output var logic I_CHIP_SEL_1_N,
  output var logic I_CHIP_SEL_2,
  output var logic I_CHIP_SEL_3_N,
  output var logic I_ADVANCE_OR_LOAD,
  output var logic I_WRITE_SEL_N,
  output var logic [3:0] I_BYTE_LANE_WRITE_N,
  output var logic I_BURST_ORDER,
  output var logic I_OUT_DRIVE_EN_N,
  output var logic I_SLEEP_REQUEST,
  output var logic [9:0] I_ADDR,
  output var logic [35:0] I_DATA_IN
);
  initial begin
    {I_CLOCK_QUALIFIER_N, I_ADVANCE_OR_LOAD, I_BURST_ORDER} = 3'h0;
    {I_OUT_DRIVE_EN_N, I_SLEEP_REQUEST, I_BYTE_LANE_WRITE_N} = 6'hF;
    {I_CHIP_SEL_1_N, I_CHIP_SEL_2, I_CHIP_SEL_3_N, I_WRITE_SEL_N} = 4'h7;
    {I_ADDR, I_DATA_IN} = 46'h0;
  end
  // Deselect drops only the third select
  task automatic op(input logic adv, cs, we_n, input logic [9:0] a,
      input logic [35:0] d, input logic [3:0] bl);
    @(negedge I_MCLK);
    I_ADVANCE_OR_LOAD = adv;
    {I_CHIP_SEL_1_N, I_CHIP_SEL_2, I_CHIP_SEL_3_N} = cs ? 3'h2 : 3'h3;
    I_WRITE_SEL_N = we_n;
    I_BYTE_LANE_WRITE_N = bl;
    I_ADDR = a;
    I_DATA_IN = d;
  endtask
endmodule
`default_nettype wire

// ===== pbsr_tb_top.sv
// Purpose: self-checking bench for pbsr_top
// Assumes: only written words are read
// Notes: read words are checked as they leave
`timescale 1ns/10ps
`default_nettype none
module pbsr_tb_top;
  logic I_MCLK = 1'h0;
  logic I_RESET = 1'h1;
  wire I_CLOCK_QUALIFIER_N, I_CHIP_SEL_1_N, I_CHIP_SEL_2, I_CHIP_SEL_3_N;
  wire I_ADVANCE_OR_LOAD, I_WRITE_SEL_N, I_BURST_ORDER, I_OUT_DRIVE_EN_N;
  wire I_SLEEP_REQUEST, O_DATA_OE, O_SLEEPING;
  wire [3:0] I_BYTE_LANE_WRITE_N;
  wire [9:0] I_ADDR;
  wire [35:0] I_DATA_IN, O_DATA_OUT;
  int bad_count = 0;
  int cmp_count = 0;
  logic [35:0] mem [0:1023];
  logic [35:0] expq [$];
  logic [1:0] frz_q = 2'h0;
  pbsr_ctl ctl (.*);
  pbsr_top dut (.*);
  initial forever #5 I_MCLK = ~I_MCLK;
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'h1) begin
      bad_count++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Advance beats flip selects and direction, which must not matter
  task automatic bst(input logic [9:0] a, input logic w, o,
      input logic [35:0] d, input logic [3:0] bl, input int n);
    logic [9:0] x;
    logic [35:0] dd;
    ctl.I_BURST_ORDER = o;
    for (int i = 0; i < n; i++) begin
      x = {a[9:2], o ? a[1:0] ^ i[1:0] : a[1:0] + i[1:0]};
      dd = d + 36'(i);
      for (int g = 0; g < 4; g++)
        if (w && !bl[g]) mem[x][9*g+:9] = dd[9*g+:9];
      if (!w) expq.push_back(mem[x]);
      ctl.op(i != 0, i == 0, (i == 0) != w, i ? ~a : a, w ? dd : ~dd, bl);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) ctl.op(1'h0, 1'h0, 1'h1, 10'h3FF, 36'hFFFFFFFFF, 4'hF);
  endtask
  // A held output word is skipped, not counted twice
  always @(posedge I_MCLK) begin
    frz_q <= {frz_q[0], I_CLOCK_QUALIFIER_N};
    if (O_DATA_OE === 1'h1 && !frz_q[1]) begin
      chk(expq.size() > 0 && O_DATA_OUT === expq[0], "read word");
      if (expq.size() > 0) void'(expq.pop_front());
    end
  end
  initial begin
    #5000;
    bad_count++;
    test_done;
  end
  initial begin
    repeat (3) @(negedge I_MCLK);
    I_RESET = 1'h0;
    bst(10'h004, 1'h1, 1'h0, 36'h123456789, 4'h0, 4);
    bst(10'h009, 1'h1, 1'h1, 36'h9ABCDEF01, 4'h0, 4);
    bst(10'h00C, 1'h1, 1'h0, 36'hFFFFFFFFF, 4'h0, 1);
    bst(10'h00C, 1'h1, 1'h0, 36'h000000000, 4'h5, 1);
    for (int o = 0; o < 2; o++)
      bst(10'h005, 1'h0, o[0], 36'h0, 4'hF, 4);
    bst(10'h00C, 1'h0, 1'h0, 36'h0, 4'hF, 1);
    bst(10'h00E, 1'h1, 1'h0, 36'h0F0F0F0F0, 4'h0, 1);
    bst(10'h00A, 1'h0, 1'h1, 36'h0, 4'hF, 4);
    bst(10'h00E, 1'h0, 1'h0, 36'h0, 4'hF, 1);
    idle(6);
    ctl.I_OUT_DRIVE_EN_N = 1'h1;
    ctl.op(1'h0, 1'h1, 1'h1, 10'h004, 36'h0, 4'hF);
    idle(8);
    ctl.I_OUT_DRIVE_EN_N = 1'h0;
    bst(10'h00C, 1'h0, 1'h0, 36'h0, 4'hF, 1);
    idle(1);
    ctl.I_CLOCK_QUALIFIER_N = 1'h1;
    repeat (3) @(negedge I_MCLK);
    ctl.I_CLOCK_QUALIFIER_N = 1'h0;
    idle(6);
    ctl.I_SLEEP_REQUEST = 1'h1;
    idle(8);
    chk(O_SLEEPING === 1'h1, "asleep");
    ctl.I_SLEEP_REQUEST = 1'h0;
    idle(8);
    chk(O_SLEEPING === 1'h0, "awake");
    bst(10'h006, 1'h0, 1'h0, 36'h0, 4'hF, 1);
    idle(8);
    chk(expq.size() == 0, "words missing");
    test_done;
  end
endmodule
`default_nettype wire
